// *** verilog/morb_defs.vh ***
// Address map, field positions and reset values of the operational register bank.
// Assumes inclusion by bare name from the bank module; holds definitions only.
`ifndef MORB_DEFS_VH
`define MORB_DEFS_VH

// Printed register indices (byte address is four times the index)
`define MORB_IDX_INDIRECT 6'h00
`define MORB_IDX_TIMER 6'h01
`define MORB_IDX_PC 6'h02
`define MORB_IDX_STATUS 6'h03
`define MORB_IDX_BANKPTR 6'h04
`define MORB_IDX_PORT5 6'h05
`define MORB_IDX_PORT6 6'h06
`define MORB_IDX_PORT7 6'h07
`define MORB_IDX_ANALOG 6'h08
`define MORB_IDX_CONV 6'h09
`define MORB_IDX_CTL_FIRST 6'h05
`define MORB_IDX_COMMON 6'h10
`define MORB_IDX_BANKED 6'h20

// Core-side sideband block, byte addresses above the data space
`define MORB_ADDR_CTLSEG 12'h100
`define MORB_ADDR_CORE 12'h140
`define MORB_ADDR_PCVIEW 12'h144

// Status field positions
`define MORB_ST_SEG 7
`define MORB_ST_PSH 6
`define MORB_ST_PSL 5
`define MORB_ST_TO 4
`define MORB_ST_PD 3
`define MORB_ST_Z 2
`define MORB_ST_DC 1
`define MORB_ST_C 0

// Bank pointer fields
`define MORB_BP_BANK_HI 7
`define MORB_BP_BANK_LO 6
`define MORB_BP_ADDR_HI 5

// Converter control: reference source select
`define MORB_CV_REFSEL 7

// Core event register bits (write one to pulse)
`define MORB_EV_SLEEP 0
`define MORB_EV_WDCLR 1
`define MORB_EV_WDTO 2
`define MORB_EV_FLAGS 3
`define MORB_EV_ZERO 4
`define MORB_EV_AUXC 5
`define MORB_EV_CARRY 6
`define MORB_EV_PCLOAD 7
`define MORB_EV_RET 8
`define MORB_EV_ZONLY 9

// Reset values and port 7 write mask
`define MORB_RST_STATUS 8'h18
`define MORB_RST_ZERO8 8'h00
`define MORB_RST_PC 12'h000
`define MORB_PORT7_MASK 8'h1F

`endif

// *** verilog/morb_register_bank.v ***
// Operational register bank of an 8-bit controller core, AHB-Lite slave.
// Assumes one 50 MHz clock, async active-low reset, single word transfers.
//
// Design decision made here: the AHB-Lite interface to the registers.
`timescale 1ns/1ns
`include "morb_defs.vh"

module morb_register_bank (
  input wire hclk, // 50 MHz bus clock
  input wire hresetn, // Async reset, active low
  input wire hsel, // Slave select
  input wire [11:0] haddr, // Byte address
  input wire [1:0] htrans, // Transfer type
  input wire hwrite, // Write when high
  input wire [2:0] hsize, // Transfer size
  input wire [31:0] hwdata, // Write data
  input wire hready, // Bus ready in
  input wire [7:0] result_in, // ALU result for flag update
  input wire [11:0] ret_addr_in, // Return address from stack
  input wire cmp_out_en, // Comparator drives shared pin
  output reg [31:0] hrdata, // Read data
  output reg hreadyout, // Low for one wait cycle on reads
  output reg hresp, // Always OKAY
  output reg [11:0] pc_out, // Program counter
  output reg [7:0] analog_pin_en, // Port 6 analog enables
  output reg pin60_analog, // Shared pin goes to ADC0
  output reg pin60_digital, // Shared pin is digital I/O
  output reg p53_is_vref, // Port 5 bit 3 is reference in
  output reg [7:0] port5_out, // Port 5 data
  output reg [7:0] port6_out, // Port 6 data
  output reg [7:0] port7_out // Port 7 data
);

  // Pointer resolution: address 0 is redirected through the bank pointer
  function [5:0] morb_resolve;
    input [5:0] a;
    input [5:0] ptr;
    begin
      morb_resolve = (a == `MORB_IDX_INDIRECT) ? ptr : a;
    end
  endfunction

  // Storage index: common rows shared, banked rows widened by bank number
  // Eight bits wide, since bank 3 rows run up to row 143
  function [7:0] morb_ram_idx;
    input [5:0] a;
    input [1:0] bank;
    begin
      if (a < `MORB_IDX_BANKED)
        morb_ram_idx = {4'h0, a[3:0]};
      else
        morb_ram_idx = {1'b0, bank, 5'h00} + 8'h10 + {3'h0, a[4:0]};
    end
  endfunction

  reg [7:0] status_r;
  reg [7:0] bankptr_r;
  reg [7:0] timer_r;
  reg [7:0] analog_r;
  reg [7:0] conv_r;
  reg [7:0] special_r [0:5]; // Offset, results, wake-up, interrupt status
  reg [7:0] ctl0_r [0:10]; // Segment 0 control, 0x05-0x0F
  reg [7:0] ctl1_r [0:10]; // Segment 1 PWM periods, duties, timers
  reg [7:0] ram_r [0:143]; // 16 common plus 4 x 32 banked
  reg [11:0] pc_r;
  reg ap_valid_r;
  reg ap_write_r;
  reg [11:0] ap_addr_r;
  integer i;

  wire [1:0] bank_sel = bankptr_r[`MORB_BP_BANK_HI:`MORB_BP_BANK_LO];
  wire [5:0] ind_ptr = bankptr_r[`MORB_BP_ADDR_HI:0];
  wire [7:0] wbyte = hwdata[7:0];
  wire in_data = (ap_addr_r[11:8] == 4'h0);
  wire in_ctl = (ap_addr_r[11:6] == `MORB_ADDR_CTLSEG >> 6);
  wire [5:0] d_idx = morb_resolve(ap_addr_r[7:2], ind_ptr);
  wire [5:0] c_idx = ap_addr_r[7:2];
  wire [3:0] c_slot = c_idx[3:0] - 4'h5;
  wire [7:0] r_idx = morb_ram_idx(d_idx, bank_sel);
  wire do_write = ap_valid_r & ap_write_r;
  wire core_wr = do_write & (ap_addr_r == `MORB_ADDR_CORE);
  wire [9:0] ev = core_wr ? hwdata[9:0] : 10'h000;

  // Address phase capture; only hready gates it, so the read wait cycle holds it
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_valid_r <= 1'b0;
      ap_write_r <= 1'b0;
      ap_addr_r <= 12'h000;
    end else if (hready) begin
      ap_valid_r <= hsel & htrans[1];
      ap_write_r <= hwrite;
      ap_addr_r <= haddr;
    end
  end

  // Status, pointer, ports, analog and converter control
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_r <= `MORB_RST_STATUS;
      bankptr_r <= `MORB_RST_ZERO8;
      timer_r <= `MORB_RST_ZERO8;
      analog_r <= `MORB_RST_ZERO8;
      conv_r <= `MORB_RST_ZERO8;
      port5_out <= `MORB_RST_ZERO8;
      port6_out <= `MORB_RST_ZERO8;
      port7_out <= `MORB_RST_ZERO8;
      for (i = 0; i < 6; i = i + 1)
        special_r[i] <= `MORB_RST_ZERO8;
    end else begin
      if (do_write && in_data && d_idx < `MORB_IDX_COMMON) begin
        case (d_idx)
          `MORB_IDX_TIMER: timer_r <= wbyte;
          `MORB_IDX_STATUS: begin
            status_r[7:5] <= wbyte[7:5];
            status_r[2:0] <= wbyte[2:0];
          end
          `MORB_IDX_BANKPTR: bankptr_r <= wbyte;
          `MORB_IDX_PORT5: port5_out <= wbyte;
          `MORB_IDX_PORT6: port6_out <= wbyte;
          `MORB_IDX_PORT7: port7_out <= wbyte & `MORB_PORT7_MASK;
          `MORB_IDX_ANALOG: analog_r <= wbyte;
          `MORB_IDX_CONV: conv_r <= wbyte;
          default: begin
            if (d_idx >= 6'h0A)
              special_r[d_idx[2:0] - 3'h2] <= wbyte;
          end
        endcase
      end
      if (ev[`MORB_EV_WDTO])
        status_r[`MORB_ST_TO] <= 1'b0;
      else if (ev[`MORB_EV_SLEEP] | ev[`MORB_EV_WDCLR])
        status_r[`MORB_ST_TO] <= 1'b1;
      if (ev[`MORB_EV_SLEEP])
        status_r[`MORB_ST_PD] <= 1'b0;
      else if (ev[`MORB_EV_WDCLR])
        status_r[`MORB_ST_PD] <= 1'b1;
      if (ev[`MORB_EV_FLAGS] | ev[`MORB_EV_ZONLY])
        status_r[`MORB_ST_Z] <= (result_in == 8'h00);
      if (ev[`MORB_EV_FLAGS]) begin
        status_r[`MORB_ST_DC] <= ev[`MORB_EV_AUXC];
        status_r[`MORB_ST_C] <= ev[`MORB_EV_CARRY];
      end
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (i = 0; i < 11; i = i + 1) begin
        ctl0_r[i] <= `MORB_RST_ZERO8;
        ctl1_r[i] <= `MORB_RST_ZERO8;
      end
    end else if (do_write && in_ctl && c_idx >= `MORB_IDX_CTL_FIRST
                 && c_idx < `MORB_IDX_COMMON) begin
      if (status_r[`MORB_ST_SEG])
        ctl1_r[c_slot] <= wbyte;
      else
        ctl0_r[c_slot] <= wbyte;
    end
  end

  // general and banked storage; not reset, like on-chip RAM
  always @(posedge hclk) begin
    if (do_write && in_data && d_idx >= `MORB_IDX_COMMON)
      ram_r[r_idx] <= wbyte;
  end

  // Program counter with page insertion
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pc_r <= `MORB_RST_PC;
    end else if (ev[`MORB_EV_RET]) begin
      pc_r <= ret_addr_in;
    end else if (ev[`MORB_EV_PCLOAD]) begin
      pc_r <= {status_r[`MORB_ST_PSH:`MORB_ST_PSL], hwdata[19:10]};
    end else if (do_write && in_data && d_idx == `MORB_IDX_PC) begin
      pc_r <= {status_r[`MORB_ST_PSH:`MORB_ST_PSL], pc_r[9:8], wbyte};
    end
  end

  // Read mux; reserved and unmapped locations read zero
  reg [7:0] rbyte;
  always @* begin
    rbyte = 8'h00;
    if (in_data) begin
      if (d_idx >= `MORB_IDX_COMMON)
        rbyte = ram_r[r_idx];
      else begin
        case (d_idx)
          `MORB_IDX_TIMER: rbyte = timer_r;
          `MORB_IDX_PC: rbyte = pc_r[7:0];
          `MORB_IDX_STATUS: rbyte = status_r;
          `MORB_IDX_BANKPTR: rbyte = bankptr_r;
          `MORB_IDX_PORT5: rbyte = port5_out;
          `MORB_IDX_PORT6: rbyte = port6_out;
          `MORB_IDX_PORT7: rbyte = port7_out;
          `MORB_IDX_ANALOG: rbyte = analog_r;
          `MORB_IDX_CONV: rbyte = conv_r;
          default: begin
            if (d_idx >= 6'h0A)
              rbyte = special_r[d_idx[2:0] - 3'h2];
          end
        endcase
      end
    end else if (in_ctl && c_idx >= `MORB_IDX_CTL_FIRST && c_idx < `MORB_IDX_COMMON) begin
      rbyte = status_r[`MORB_ST_SEG] ? ctl1_r[c_slot] : ctl0_r[c_slot];
    end
  end

  // Registered read data and pin routing outputs
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      pc_out <= `MORB_RST_PC;
      analog_pin_en <= `MORB_RST_ZERO8;
      pin60_analog <= 1'b0;
      pin60_digital <= 1'b1;
      p53_is_vref <= 1'b0;
    end else begin
      hresp <= 1'b0;
      // One wait state on reads: a write landing at the address edge is seen
      hreadyout <= 1'b1;
      if (hready && hsel && htrans[1] && !hwrite)
        hreadyout <= 1'b0;
      // Read data captured in the wait cycle, stands when ready rises
      if (!hreadyout && ap_valid_r && !ap_write_r)
        hrdata <= (ap_addr_r == `MORB_ADDR_PCVIEW) ? {20'h00000, pc_r}
                  : {24'h000000, rbyte};
      pc_out <= pc_r;
      analog_pin_en <= analog_r;
      pin60_analog <= !cmp_out_en && analog_r[0];
      pin60_digital <= !cmp_out_en && !analog_r[0];
      p53_is_vref <= conv_r[`MORB_CV_REFSEL];
    end
  end

endmodule // morb_register_bank

// *** dv/morb_chk.sv ***
// Checker: bus answer, port copies, pin routing, program counter loads.
// Assumes bind onto the bank top with hready fed back from hreadyout.
`timescale 1ns/1ns
module morb_chk (
  input wire hclk, // Clock
  input wire hresetn, // Reset
  input wire hsel, // Select
  input wire [11:0] haddr, // Address
  input wire [1:0] htrans, // Type
  input wire hwrite, // Write
  input wire [31:0] hwdata, // Data
  input wire hready, // Ready in
  input wire [11:0] ret_addr_in, // Return
  input wire cmp_out_en, // Comparator
  input wire hreadyout, // Ready
  input wire hresp, // Response
  input wire [11:0] pc_out, // PC
  input wire [7:0] analog_pin_en, // Analog
  input wire pin60_analog, // To ADC
  input wire pin60_digital, // To I/O
  input wire p53_is_vref, // Vref
  input wire [7:0] port5_out, // Port 5
  input wire [7:0] port7_out // Port 7
);
  default clocking dc @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  // Write address kept for its data phase
  reg wv_q;
  reg [11:0] wa_q;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wv_q <= 1'b0;
      wa_q <= 12'h000;
    end else begin
      wv_q <= hsel && hready && htrans == 2'h2 && hwrite;
      wa_q <= haddr;
    end
  end
  // Event word in its data phase
  wire ev = wv_q && wa_q == 12'h140;
  bus_okay_a: assert property (!hresp)
    else $error("bus answer not okay");
  read_wait_a: assert property (hsel && hready && htrans == 2'h2 && !hwrite |=>
    !hreadyout ##1 hreadyout) else $error("read wait state wrong");
  write_nowait_a: assert property (hsel && hready && htrans == 2'h2 && hwrite |=>
    hreadyout) else $error("write not zero wait");
  port7_top_a: assert property (port7_out[7:5] == 3'h0)
    else $error("port 7 upper bits set");
  port5_wr_a: assert property (wv_q && wa_q == 12'h014 |->
    ##1 port5_out == $past(hwdata[7:0])) else $error("port 5 not written");
  analog_copy_a: assert property (wv_q && wa_q == 12'h020 |->
    ##2 analog_pin_en == $past(hwdata[7:0], 2)) else $error("analog enables wrong");
  vref_copy_a: assert property (wv_q && wa_q == 12'h024 |->
    ##2 p53_is_vref == $past(hwdata[7], 2)) else $error("reference select wrong");
  cmp_owns_a: assert property (cmp_out_en [*3] |->
    !pin60_analog && !pin60_digital) else $error("comparator lost shared pin");
  jump_low_a: assert property (ev && hwdata[7] && !hwdata[8] |->
    ##2 pc_out[9:0] == $past(hwdata[19:10], 2)) else $error("jump target wrong");
  ret_load_a: assert property (ev && hwdata[8] && !hwdata[7] |->
    ##2 pc_out == $past(ret_addr_in, 2)) else $error("return address wrong");
endmodule // morb_chk

bind morb_register_bank morb_chk u_chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
  .hwdata, .hready, .ret_addr_in, .cmp_out_en, .hreadyout, .hresp, .pc_out, .analog_pin_en,
  .pin60_analog, .pin60_digital, .p53_is_vref, .port5_out, .port7_out);

// *** dv/tb_top.sv ***
// Bench for the register bank: AHB-Lite master tasks, random and corner data.
// Assumes zero-wait writes; reads get one wait state, data taken with ready.
`timescale 1ns/1ns
module tb_top;
  reg hclk = 1'b0;
  reg hresetn = 1'b0;
  reg hsel = 1'b0;
  reg hwrite = 1'b0;
  reg cmp_out_en = 1'b0;
  reg [1:0] htrans = 2'h0;
  reg [2:0] hsize = 3'h2;
  reg [11:0] haddr = 12'h000;
  reg [11:0] ret_addr_in = 12'h000;
  reg [7:0] result_in = 8'h00;
  reg [31:0] hwdata = 32'h0;
  reg [31:0] seed = 32'h7EB576F6;
  reg [7:0] bd [0:3];
  reg [31:0] v;
  int miscompares = 0;
  int comparisons = 0;
  int cyc = 0;
  int i;
  wire hready;
  wire hreadyout;
  wire hresp;
  wire pin60_analog;
  wire pin60_digital;
  wire p53_is_vref;
  wire [31:0] hrdata;
  wire [11:0] pc_out;
  wire [7:0] analog_pin_en;
  wire [7:0] port5_out;
  wire [7:0] port6_out;
  wire [7:0] port7_out;
  // One slave, so its ready is the bus ready
  assign hready = hreadyout;
  morb_register_bank DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .result_in, .ret_addr_in, .cmp_out_en, .hrdata, .hreadyout, .hresp, .pc_out,
    .analog_pin_en, .pin60_analog, .pin60_digital, .p53_is_vref, .port5_out, .port6_out,
    .port7_out);
  initial begin
    forever #10 hclk = ~hclk;
  end
  // A few hundred cycles expected; ceiling leaves wide margin
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      miscompares++;
      finish_test;
    end
  end
  function automatic [31:0] rnd();
    begin
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      rnd = seed;
    end
  endfunction
  // Page bits land on the top of the 12-bit counter
  function [31:0] pcx(input [1:0] p, input [9:0] lo);
    pcx = {20'h0, p, lo};
  endfunction
  task finish_test;
    begin
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  // Values are taken when the call is made, at the sampling edge
  task chk(input string n, input [31:0] e, input [31:0] s);
    begin
      comparisons++;
      if (s !== e) begin
        miscompares++;
        $display("MISMATCH %s expected %h seen %h", n, e, s);
      end
    end
  endtask
  task ap(input [11:0] a, input w);
    begin
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= w;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      htrans <= 2'h0;
    end
  endtask
  task dp;
    begin
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
    end
  endtask
  task wr(input [11:0] a, input [31:0] d);
    begin
      ap(a, 1'b1);
      hwdata <= d;
      dp;
    end
  endtask
  // Read data taken at the edge where ready is sampled high
  task rd(input string n, input [11:0] a, input [31:0] e);
    begin
      ap(a, 1'b0);
      dp;
      chk(n, e, hrdata);
    end
  endtask
  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    rd("status", 12'h00C, 32'h18);
    rd("pc", 12'h144, 32'h0);
    wr(12'h00C, 32'h0);
    rd("status", 12'h00C, 32'h18);
    wr(12'h140, 32'h004);
    rd("status", 12'h00C, 32'h08);
    wr(12'h140, 32'h001);
    rd("status", 12'h00C, 32'h10);
    wr(12'h140, 32'h004);
    rd("status", 12'h00C, 32'h00);
    wr(12'h140, 32'h002);
    rd("status", 12'h00C, 32'h18);
    wr(12'h140, 32'h028);
    rd("status", 12'h00C, 32'h1E);
    result_in <= 8'h5A;
    wr(12'h140, 32'h200);
    rd("status", 12'h00C, 32'h1A);
    wr(12'h140, 32'h048);
    rd("status", 12'h00C, 32'h19);
    for (i = 0; i < 4; i++) begin
      v = rnd();
      wr(12'h00C, {24'h0, 1'b0, i[1:0], 5'h00});
      wr(12'h140, {12'h0, v[9:0], 10'h080});
      rd("pc", 12'h144, pcx(i[1:0], v[9:0]));
    end
    ret_addr_in <= v[31:20];
    wr(12'h140, 32'h100);
    rd("pc", 12'h144, {20'h0, v[31:20]});
    rd("status", 12'h00C, 32'h78);
    for (i = 0; i < 4; i++) begin
      v = rnd();
      bd[i] = v[7:0];
      wr(12'h010, {24'h0, i[1:0], 6'h00});
      wr(12'h080, {24'h0, bd[i]});
    end
    wr(12'h040, 32'hA5);
    for (i = 0; i < 4; i++) begin
      wr(12'h010, {24'h0, i[1:0], 6'h00});
      rd("banked", 12'h080, {24'h0, bd[i]});
      rd("common", 12'h040, 32'hA5);
    end
    v = rnd();
    wr(12'h014, {24'h0, v[31:24]});
    @(posedge hclk);
    chk("port5", {24'h0, v[31:24]}, {24'h0, port5_out});
    wr(12'h010, 32'h05);
    wr(12'h000, {24'h0, v[7:0]});
    rd("port5", 12'h014, {24'h0, v[7:0]});
    rd("indirect", 12'h000, {24'h0, v[7:0]});
    wr(12'h01C, 32'hFF);
    rd("port7", 12'h01C, 32'h1F);
    wr(12'h018, {24'h0, v[15:8]});
    @(posedge hclk);
    chk("port6", {24'h0, v[15:8]}, {24'h0, port6_out});
    wr(12'h020, {24'h0, v[23:16]});
    repeat (2) @(posedge hclk);
    chk("analog", {24'h0, v[23:16]}, {24'h0, analog_pin_en});
    rd("analog", 12'h020, {24'h0, v[23:16]});
    // Pin owner: ADC alone, comparator over ADC, then digital
    for (i = 0; i < 3; i++) begin
      wr(12'h020, {31'h0, i < 2});
      cmp_out_en <= (i == 1);
      repeat (3) @(posedge hclk);
      chk("to_adc", {31'h0, i == 0}, {31'h0, pin60_analog});
      chk("to_io", {31'h0, i == 2}, {31'h0, pin60_digital});
    end
    for (i = 0; i < 2; i++) begin
      wr(12'h024, {24'h0, i == 0, 7'h00});
      repeat (2) @(posedge hclk);
      chk("vref", {31'h0, i == 0}, {31'h0, p53_is_vref});
    end
    wr(12'h00C, 32'h00);
    wr(12'h114, 32'h3C);
    wr(12'h00C, 32'h80);
    wr(12'h114, 32'hC3);
    rd("seg1", 12'h114, 32'hC3);
    wr(12'h00C, 32'h00);
    rd("seg0", 12'h114, 32'h3C);
    rd("reserved", 12'h100, 32'h00);
    rd("unmapped", 12'h180, 32'h00);
    finish_test;
  end
endmodule // tb_top
